/* File: verilog/iwd_defines.vh */
`ifndef IWD_DEFINES_VH
`define IWD_DEFINES_VH
// field positions
`define IWD_TOP_HI 13
`define IWD_TOP_LO 12
`define IWD_SUB_HI 11
`define IWD_SUB_LO 8
`define IWD_DEST_BIT 7
`define IWD_FILE_HI 6
`define IWD_BITNUM_HI 9
`define IWD_BITNUM_LO 7
`define IWD_LIT_HI 7
`define IWD_TGT_HI 10
// top-level classes
`define IWD_TOP_BYTE 2'h0
`define IWD_TOP_BIT 2'h1
`define IWD_TOP_JUMP 2'h2
`define IWD_TOP_LIT 2'h3
// byte-oriented sub-opcodes
`define IWD_B_MISC 4'h0
`define IWD_B_CLR 4'h1
`define IWD_B_SUB 4'h2
`define IWD_B_DEC 4'h3
`define IWD_B_IOR 4'h4
`define IWD_B_AND 4'h5
`define IWD_B_XOR 4'h6
`define IWD_B_ADD 4'h7
`define IWD_B_MOV 4'h8
`define IWD_B_COM 4'h9
`define IWD_B_INC 4'hA
`define IWD_B_DECSZ 4'hB
`define IWD_B_ROTR 4'hC
`define IWD_B_ROTL 4'hD
`define IWD_B_SWAP 4'hE
`define IWD_B_INCSZ 4'hF
// fixed control words
`define IWD_W_RETFI 14'h0009
`define IWD_W_RET 14'h0008
`define IWD_W_SLEEP 14'h0063
`define IWD_W_WDT 14'h0064
// timer zero counter file address
`define IWD_TIMER0_ADDR 7'h01
// operation codes on opCode output
`define IWD_OP_NOP 6'h00
`define IWD_OP_ADD_FILE 6'h01
`define IWD_OP_AND_FILE 6'h02
`define IWD_OP_CLEAR_FILE 6'h03
`define IWD_OP_CLEAR_WREG 6'h04
`define IWD_OP_COMP_FILE 6'h05
`define IWD_OP_DEC_FILE 6'h06
`define IWD_OP_DECSZ 6'h07
`define IWD_OP_INC_FILE 6'h08
`define IWD_OP_INCSZ 6'h09
`define IWD_OP_OR_FILE 6'h0A
`define IWD_OP_MOVE_FILE 6'h0B
`define IWD_OP_STORE_WREG 6'h0C
`define IWD_OP_ROT_LEFT 6'h0D
`define IWD_OP_ROT_RIGHT 6'h0E
`define IWD_OP_SUB_FILE 6'h0F
`define IWD_OP_SWAP_FILE 6'h10
`define IWD_OP_XOR_FILE 6'h11
`define IWD_OP_BIT_CLEAR 6'h12
`define IWD_OP_BIT_SET 6'h13
`define IWD_OP_TEST_CLEAR 6'h14
`define IWD_OP_TEST_SET 6'h15
`define IWD_OP_ADD_LIT 6'h16
`define IWD_OP_AND_LIT 6'h17
`define IWD_OP_CALL 6'h18
`define IWD_OP_WDT 6'h19
`define IWD_OP_JUMP 6'h1A
`define IWD_OP_OR_LIT 6'h1B
`define IWD_OP_LOAD_LIT 6'h1C
`define IWD_OP_RETFI 6'h1D
`define IWD_OP_RET_LIT 6'h1E
`define IWD_OP_RET 6'h1F
`define IWD_OP_SLEEP 6'h20
`define IWD_OP_SUB_LIT 6'h21
`define IWD_OP_XOR_LIT 6'h22
`define IWD_OP_ILLEGAL 6'h3F
// phases per instruction cycle
`define IWD_PHASES 4
`define IWD_NOP_WORD 14'h0000
`endif

/* File: verilog/iwd_decoder.v */
// Contract
// - file operand is seven-bit address 00..7F
// - d=0 writes W, d=1 writes file
// - bit word: opcode, bit number, file
// - literal words carry eight-bit immediate
// - call/jump carry eleven-bit target, two cycles
// - decode add, and, or, xor, subtract
// - decode com/dec/inc/mov/swap; zero except swap
// - rotates through carry update carry only
// - skip-zero ops skip, no flags
// - clear file/W set zero; store W
// - bit clear/set/test-skip, no flags
// - decode literal arithmetic and load ops
// - add/sub: carry, digit carry, zero; logic: zero
// - returns recognised, two cycles each
// - standby, watchdog clear update timeout, powerdown flags
// - port read-modify-write reads pin levels
// - timer zero write clears its prescaler
// - PC change or skip: two cycles, NO_OPERATION
// - cycle is four clocks, one instruction
// - file ops read before write back
`timescale 1ns/1ns
`include "iwd_defines.vh"
module iwd_decoder #(
  parameter PHASES = `IWD_PHASES
)(
  input wire mclk,
  input wire arst_n,
  input wire [13:0] fetchWord,
  input wire fetchValid,
  input wire skipTaken,
  input wire fileIsPort,
  input wire prescalerOnTimer,
  output wire [13:0] instrWord,
  output wire cycleStart,
  output wire [1:0] cyclePhase,
  output wire secondCycle,
  output reg [5:0] opCode,
  output wire [6:0] fileAddr,
  output wire destFile,
  output wire [2:0] bitNum,
  output wire [7:0] literal,
  output wire [10:0] jumpTarget,
  output reg writesWreg,
  output reg writesFile,
  output reg readsFile,
  output reg readPins,
  output reg updC,
  output reg updDc,
  output reg updZ,
  output reg setZ,
  output reg updToPd,
  output reg isSkipOp,
  output reg changesPc,
  output reg twoCycle,
  output reg clearPrescaler,
  output reg illegalOp
);

////////////////////////////////////////////////////////////////////////////////
// instruction cycle phases and instruction register
reg [1:0] phase_r;
reg [13:0] ir_r;
reg second_r;
reg [13:0] ir_nxt;
reg second_nxt;
wire cycleEnd;
wire needSecond;

assign cycleEnd = (phase_r == PHASES - 1);
assign cycleStart = (phase_r == 2'h0);
assign cyclePhase = phase_r;
assign secondCycle = second_r;
assign instrWord = ir_r;
// pc change or skip true needs a second, empty cycle
assign needSecond = !second_r && (changesPc || (isSkipOp && skipTaken));

always @*
begin
  ir_nxt = ir_r;
  second_nxt = second_r;
  if (cycleEnd)
  begin
    if (needSecond)
    begin
      ir_nxt = `IWD_NOP_WORD;
      second_nxt = 1'b1;
    end
    else
    begin
      ir_nxt = fetchValid ? fetchWord : `IWD_NOP_WORD;
      second_nxt = 1'b0;
    end
  end
end

always @(posedge mclk or negedge arst_n)
begin
  if (!arst_n)
  begin
    phase_r <= 2'h0;
    ir_r <= `IWD_NOP_WORD;
    second_r <= 1'b0;
  end
  else
  begin
    phase_r <= cycleEnd ? 2'h0 : phase_r + 2'h1;
    ir_r <= ir_nxt;
    second_r <= second_nxt;
  end
end

////////////////////////////////////////////////////////////////////////////////
// field extraction
wire [1:0] topBits;
wire [3:0] subOp;
assign topBits = ir_r[`IWD_TOP_HI:`IWD_TOP_LO];
assign subOp = ir_r[`IWD_SUB_HI:`IWD_SUB_LO];
assign fileAddr = ir_r[`IWD_FILE_HI:0];
assign destFile = ir_r[`IWD_DEST_BIT];
assign bitNum = ir_r[`IWD_BITNUM_HI:`IWD_BITNUM_LO];
assign literal = ir_r[`IWD_LIT_HI:0];
assign jumpTarget = ir_r[`IWD_TGT_HI:0];

////////////////////////////////////////////////////////////////////////////////
// operation decode
always @*
begin
  opCode = `IWD_OP_ILLEGAL;
  writesWreg = 1'b0;
  writesFile = 1'b0;
  readsFile = 1'b0;
  updC = 1'b0;
  updDc = 1'b0;
  updZ = 1'b0;
  setZ = 1'b0;
  updToPd = 1'b0;
  isSkipOp = 1'b0;
  changesPc = 1'b0;
  illegalOp = 1'b0;
  case (topBits)
    `IWD_TOP_BYTE:
    begin
      readsFile = 1'b1;
      writesWreg = !destFile;
      writesFile = destFile;
      case (subOp)
        `IWD_B_MISC:
        begin
          readsFile = destFile;
          writesWreg = 1'b0;
          if (destFile)
            opCode = `IWD_OP_STORE_WREG;
          else
          begin
            writesFile = 1'b0;
            if (ir_r == `IWD_W_RETFI)
            begin
              opCode = `IWD_OP_RETFI;
              changesPc = 1'b1;
            end
            else if (ir_r == `IWD_W_RET)
            begin
              opCode = `IWD_OP_RET;
              changesPc = 1'b1;
            end
            else if (ir_r == `IWD_W_SLEEP)
            begin
              opCode = `IWD_OP_SLEEP;
              updToPd = 1'b1;
            end
            else if (ir_r == `IWD_W_WDT)
            begin
              opCode = `IWD_OP_WDT;
              updToPd = 1'b1;
            end
            else if (ir_r[4:0] == 5'h00)
              opCode = `IWD_OP_NOP;
            else
            begin
              opCode = `IWD_OP_NOP;
              illegalOp = 1'b1;
            end
          end
        end
        `IWD_B_CLR:
        begin
          // low seven bits ignored for clear W
          opCode = destFile ? `IWD_OP_CLEAR_FILE : `IWD_OP_CLEAR_WREG;
          readsFile = destFile;
          updZ = 1'b1;
          setZ = 1'b1;
        end
        `IWD_B_SUB:
        begin
          opCode = `IWD_OP_SUB_FILE;
          {updC, updDc, updZ} = 3'h7;
        end
        `IWD_B_DEC:
        begin
          opCode = `IWD_OP_DEC_FILE;
          updZ = 1'b1;
        end
        `IWD_B_IOR:
        begin
          opCode = `IWD_OP_OR_FILE;
          updZ = 1'b1;
        end
        `IWD_B_AND:
        begin
          opCode = `IWD_OP_AND_FILE;
          updZ = 1'b1;
        end
        `IWD_B_XOR:
        begin
          opCode = `IWD_OP_XOR_FILE;
          updZ = 1'b1;
        end
        `IWD_B_ADD:
        begin
          opCode = `IWD_OP_ADD_FILE;
          {updC, updDc, updZ} = 3'h7;
        end
        `IWD_B_MOV:
        begin
          opCode = `IWD_OP_MOVE_FILE;
          updZ = 1'b1;
        end
        `IWD_B_COM:
        begin
          opCode = `IWD_OP_COMP_FILE;
          updZ = 1'b1;
        end
        `IWD_B_INC:
        begin
          opCode = `IWD_OP_INC_FILE;
          updZ = 1'b1;
        end
        `IWD_B_DECSZ:
        begin
          opCode = `IWD_OP_DECSZ;
          isSkipOp = 1'b1;
        end
        `IWD_B_ROTR:
        begin
          opCode = `IWD_OP_ROT_RIGHT;
          updC = 1'b1;
        end
        `IWD_B_ROTL:
        begin
          opCode = `IWD_OP_ROT_LEFT;
          updC = 1'b1;
        end
        `IWD_B_SWAP:
          opCode = `IWD_OP_SWAP_FILE;
        `IWD_B_INCSZ:
        begin
          opCode = `IWD_OP_INCSZ;
          isSkipOp = 1'b1;
        end
        default:
          opCode = `IWD_OP_ILLEGAL;
      endcase
    end
    `IWD_TOP_BIT:
    begin
      readsFile = 1'b1;
      case (subOp[3:2])
        2'h0:
        begin
          opCode = `IWD_OP_BIT_CLEAR;
          writesFile = 1'b1;
        end
        2'h1:
        begin
          opCode = `IWD_OP_BIT_SET;
          writesFile = 1'b1;
        end
        2'h2:
        begin
          opCode = `IWD_OP_TEST_CLEAR;
          isSkipOp = 1'b1;
        end
        default:
        begin
          opCode = `IWD_OP_TEST_SET;
          isSkipOp = 1'b1;
        end
      endcase
    end
    `IWD_TOP_JUMP:
    begin
      opCode = ir_r[11] ? `IWD_OP_JUMP : `IWD_OP_CALL;
      changesPc = 1'b1;
    end
    default:
    begin
      writesWreg = 1'b1;
      casez (subOp)
        4'b111?:
        begin
          opCode = `IWD_OP_ADD_LIT;
          {updC, updDc, updZ} = 3'h7;
        end
        4'b110?:
        begin
          opCode = `IWD_OP_SUB_LIT;
          {updC, updDc, updZ} = 3'h7;
        end
        4'b1001:
        begin
          opCode = `IWD_OP_AND_LIT;
          updZ = 1'b1;
        end
        4'b1000:
        begin
          opCode = `IWD_OP_OR_LIT;
          updZ = 1'b1;
        end
        4'b1010:
        begin
          opCode = `IWD_OP_XOR_LIT;
          updZ = 1'b1;
        end
        4'b00??:
          opCode = `IWD_OP_LOAD_LIT;
        4'b01??:
        begin
          opCode = `IWD_OP_RET_LIT;
          changesPc = 1'b1;
        end
        default:
        begin
          opCode = `IWD_OP_ILLEGAL;
          writesWreg = 1'b0;
          illegalOp = 1'b1;
        end
      endcase
    end
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// side effects and cycle count
always @*
begin
  readPins = readsFile && fileIsPort;
  clearPrescaler = writesFile && prescalerOnTimer &&
    (fileAddr == `IWD_TIMER0_ADDR) && !second_r;
  twoCycle = changesPc || (isSkipOp && skipTaken);
end

endmodule // iwd_decoder

/* File: test/iwd_decoder_assertions.sv */
`timescale 1ns/1ns
`include "iwd_defines.vh"
module iwd_decoder_checker (
  input wire mclk,
  input wire arst_n,
  input wire [13:0] fetchWord,
  input wire fetchValid,
  input wire skipTaken,
  input wire fileIsPort,
  input wire prescalerOnTimer,
  input wire [13:0] instrWord,
  input wire cycleStart,
  input wire [1:0] cyclePhase,
  input wire secondCycle,
  input wire [5:0] opCode,
  input wire [6:0] fileAddr,
  input wire destFile,
  input wire [2:0] bitNum,
  input wire [7:0] literal,
  input wire [10:0] jumpTarget,
  input wire writesWreg,
  input wire writesFile,
  input wire readsFile,
  input wire readPins,
  input wire isSkipOp,
  input wire changesPc,
  input wire twoCycle,
  input wire clearPrescaler
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////
  sequence s_quiet;
    (!cycleStart)[*3];
  endsequence
  sequence s_nop;
    (secondCycle && opCode == `IWD_OP_NOP && instrWord == 14'h0000)[*4];
  endsequence
  property p_fields;
    fileAddr == instrWord[6:0] && destFile == instrWord[7] && bitNum == instrWord[9:7]
      && literal == instrWord[7:0] && jumpTarget == instrWord[10:0];
  endproperty
  property p_cycle;
    (cyclePhase == 2'h0) |-> cycleStart ##1 s_quiet ##1 cycleStart;
  endproperty
  property p_take;
    (cyclePhase == 2'h3 && !twoCycle) |=>
      instrWord == ($past(fetchValid) ? $past(fetchWord) : `IWD_NOP_WORD) && !secondCycle;
  endproperty
  property p_second;
    (cyclePhase == 2'h3 && twoCycle) |=> s_nop ##1 !secondCycle;
  endproperty
  property p_hold;
    (cyclePhase != 2'h0) |-> $stable(instrWord) && $stable(opCode);
  endproperty
  property p_two;
    twoCycle == (changesPc || (isSkipOp && skipTaken));
  endproperty
  property p_pc;
    changesPc == (opCode inside {`IWD_OP_CALL, `IWD_OP_JUMP, `IWD_OP_RET, `IWD_OP_RETFI,
      `IWD_OP_RET_LIT});
  endproperty
  property p_pins;
    readPins == (readsFile && fileIsPort);
  endproperty
  property p_presc;
    clearPrescaler == (writesFile && prescalerOnTimer && fileAddr == `IWD_TIMER0_ADDR
      && !secondCycle);
  endproperty
  property p_dest;
    (opCode == `IWD_OP_ADD_FILE) |-> writesFile == destFile && writesWreg == !destFile;
  endproperty
  property p_rmw;
    writesFile |-> readsFile;
  endproperty
  a_fields: assert property (p_fields) else $error("field split wrong");
  a_cycle: assert property (p_cycle) else $error("cycle length wrong");
  a_take: assert property (p_take) else $error("word not taken");
  a_second: assert property (p_second) else $error("second cycle wrong");
  a_hold: assert property (p_hold) else $error("word moved in cycle");
  a_two: assert property (p_two) else $error("cycle count wrong");
  a_pc: assert property (p_pc) else $error("pc change wrong");
  a_pins: assert property (p_pins) else $error("pin read wrong");
  a_presc: assert property (p_presc) else $error("prescaler clear wrong");
  a_dest: assert property (p_dest) else $error("destination wrong");
  a_rmw: assert property (p_rmw) else $error("write without read");
endmodule // iwd_decoder_checker

bind iwd_decoder iwd_decoder_checker u_chk (.mclk, .arst_n, .fetchWord, .fetchValid,
  .skipTaken, .fileIsPort, .prescalerOnTimer, .instrWord, .cycleStart, .cyclePhase,
  .secondCycle, .opCode, .fileAddr, .destFile, .bitNum, .literal, .jumpTarget, .writesWreg,
  .writesFile, .readsFile, .readPins, .isSkipOp, .changesPc, .twoCycle, .clearPrescaler);

/* File: test/iwd_fetch_model.sv */
`timescale 1ns/1ns
module iwd_fetch_model (
  input wire mclk,
  input wire [1:0] cyclePhase,
  input wire [13:0] nextWord,
  input wire nextValid,
  output logic [13:0] fetchWord,
  output logic fetchValid
);
  initial fetchWord = 14'h0000;
  initial fetchValid = 1'b0;
  // word shown only in the taking phase, garbage otherwise
  always @(posedge mclk)
  begin
    #1;
    fetchWord = (cyclePhase == 2'h3) ? nextWord : ~fetchWord;
    fetchValid = (cyclePhase == 2'h3) ? nextValid : ~fetchValid;
  end
endmodule // iwd_fetch_model

/* File: test/iwd_decoder_tb_top.sv */
`timescale 1ns/1ns
`include "iwd_defines.vh"
module iwd_decoder_tb_top;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [13:0] nextWord = 14'h0000;
  logic nextValid = 1'b1;
  logic skipTaken = 1'b0;
  logic fileIsPort = 1'b0;
  logic prescalerOnTimer = 1'b0;
  wire [13:0] fetchWord, instrWord;
  wire [1:0] cyclePhase;
  wire [5:0] opCode;
  wire [6:0] fileAddr;
  wire [2:0] bitNum;
  wire [7:0] literal;
  wire [10:0] jumpTarget;
  wire fetchValid, cycleStart, secondCycle, destFile, writesWreg, writesFile, readsFile;
  wire readPins, updC, updDc, updZ, setZ, updToPd, isSkipOp, changesPc, twoCycle;
  wire clearPrescaler, illegalOp;
  integer errors = 0, checkCount = 0, cycles = 0, i, n;
  logic [24:0] rows [0:34] = '{
    {14'h07FF,`IWD_OP_ADD_FILE,5'h1C}, {14'h0555,`IWD_OP_AND_FILE,5'h04},
    {14'h0180,`IWD_OP_CLEAR_FILE,5'h04}, {14'h017F,`IWD_OP_CLEAR_WREG,5'h04},
    {14'h0900,`IWD_OP_COMP_FILE,5'h04}, {14'h0300,`IWD_OP_DEC_FILE,5'h04},
    {14'h0B00,`IWD_OP_DECSZ,5'h01}, {14'h0A00,`IWD_OP_INC_FILE,5'h04},
    {14'h0F80,`IWD_OP_INCSZ,5'h01}, {14'h0400,`IWD_OP_OR_FILE,5'h04},
    {14'h0800,`IWD_OP_MOVE_FILE,5'h04}, {14'h0080,`IWD_OP_STORE_WREG,5'h00},
    {14'h0060,`IWD_OP_NOP,5'h00}, {14'h0D00,`IWD_OP_ROT_LEFT,5'h10},
    {14'h0C00,`IWD_OP_ROT_RIGHT,5'h10}, {14'h0200,`IWD_OP_SUB_FILE,5'h1C},
    {14'h0E00,`IWD_OP_SWAP_FILE,5'h00}, {14'h0600,`IWD_OP_XOR_FILE,5'h04},
    {14'h1000,`IWD_OP_BIT_CLEAR,5'h00}, {14'h1400,`IWD_OP_BIT_SET,5'h00},
    {14'h1800,`IWD_OP_TEST_CLEAR,5'h01}, {14'h1C00,`IWD_OP_TEST_SET,5'h01},
    {14'h3F00,`IWD_OP_ADD_LIT,5'h1C}, {14'h3900,`IWD_OP_AND_LIT,5'h04},
    {14'h2000,`IWD_OP_CALL,5'h01}, {14'h0064,`IWD_OP_WDT,5'h02},
    {14'h2FFF,`IWD_OP_JUMP,5'h01}, {14'h3800,`IWD_OP_OR_LIT,5'h04},
    {14'h33FF,`IWD_OP_LOAD_LIT,5'h00}, {14'h0009,`IWD_OP_RETFI,5'h01},
    {14'h3700,`IWD_OP_RET_LIT,5'h01}, {14'h0008,`IWD_OP_RET,5'h01},
    {14'h0063,`IWD_OP_SLEEP,5'h02}, {14'h3D00,`IWD_OP_SUB_LIT,5'h1C},
    {14'h3A00,`IWD_OP_XOR_LIT,5'h04}};
  ////////////////////////////////////////////////////////////////
  iwd_decoder dut (.mclk, .arst_n, .fetchWord, .fetchValid, .skipTaken, .fileIsPort,
    .prescalerOnTimer, .instrWord, .cycleStart, .cyclePhase, .secondCycle, .opCode, .fileAddr,
    .destFile, .bitNum, .literal, .jumpTarget, .writesWreg, .writesFile, .readsFile,
    .readPins, .updC, .updDc, .updZ, .setZ, .updToPd, .isSkipOp, .changesPc, .twoCycle,
    .clearPrescaler, .illegalOp);
  iwd_fetch_model fetch (.mclk, .cyclePhase, .nextWord, .nextValid, .fetchWord, .fetchValid);
  always #5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////
  task print_verdict;
  begin
    $display("checks %0d errors %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task chk(input logic ok, input string msg);
  begin
    checkCount = checkCount + 1;
    if (ok !== 1'b1)
    begin
      errors = errors + 1;
      $display("[ERR] %0t %s", $time, msg);
    end
  end
  endtask
  // waits until the word is taken; m = skip, port, prescaler
  task issue(input logic [13:0] w, input logic v, input logic [2:0] m, output integer k);
  begin
    nextWord = w;
    nextValid = v;
    k = 0;
    do
    begin
      @(posedge mclk);
      #1;
      k = k + 1;
    end
    while (k < 12 && !(cyclePhase === 2'h0 && secondCycle === 1'b0));
    {skipTaken, fileIsPort, prescalerOnTimer} = m;
    #1;
    chk(k < 12, "word never taken");
  end
  endtask
  always @(posedge mclk)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      errors = errors + 1;
      print_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge mclk);
    #1 arst_n = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(instrWord === 14'h0000 && opCode === `IWD_OP_NOP && cyclePhase === 2'h2,
      "reset");
    issue(14'h0755, 1'b1, 3'h0, n);
    chk(n === 2, "first take edge");
    chk(writesWreg === 1'b1 && writesFile === 1'b0 && fileAddr === 7'h55, "d0");
    $display("reset test done");
    for (i = 0; i < 35; i = i + 1)
    begin
      issue(rows[i][24:11], 1'b1, 3'h4, n);
      chk(opCode === rows[i][10:5], "opcode");
      chk({updC, updDc, updZ, updToPd, twoCycle} === rows[i][4:0], "flags");
    end
    $display("table test done");
    issue(14'h0B00, 1'b1, 3'h0, n);
    chk(twoCycle === 1'b0, "skip not taken");
    issue(14'h1BAB, 1'b1, 3'h4, n);
    chk(n === 4 && bitNum === 3'h7 && fileAddr === 7'h2B, "bit fields");
    issue(14'h3CA5, 1'b1, 3'h0, n);
    chk(n === 8 && literal === 8'hA5, "literal");
    issue(14'h2ABC, 1'b1, 3'h0, n);
    chk(jumpTarget === 11'h2BC && twoCycle === 1'b1, "target");
    $display("skip test done");
    issue(14'h0185, 1'b1, 3'h0, n);
    chk(setZ === 1'b1 && writesFile === 1'b1 && readsFile === 1'b1, "clear");
    issue(14'h07D5, 1'b1, 3'h2, n);
    chk(writesFile === 1'b1 && writesWreg === 1'b0 && readPins === 1'b1, "d1");
    issue(14'h3086, 1'b1, 3'h3, n);
    chk(readPins === 1'b0 && clearPrescaler === 1'b0, "literal port");
    issue(14'h0081, 1'b1, 3'h1, n);
    chk(clearPrescaler === 1'b1, "timer write");
    issue(14'h0701, 1'b1, 3'h1, n);
    chk(clearPrescaler === 1'b0, "timer to w");
    issue(14'h0081, 1'b1, 3'h0, n);
    chk(clearPrescaler === 1'b0, "not assigned");
    $display("side effect test done");
    issue(14'h07FF, 1'b0, 3'h0, n);
    chk(instrWord === 14'h0000 && opCode === `IWD_OP_NOP, "invalid fetch");
    issue(14'h0001, 1'b1, 3'h0, n);
    chk(illegalOp === 1'b1, "illegal");
    issue(14'h0060, 1'b1, 3'h0, n);
    chk(illegalOp === 1'b0 && opCode === `IWD_OP_NOP, "nop form");
    issue(14'h2000, 1'b1, 3'h0, n);
    @(posedge mclk);
    #1 arst_n = 1'b0;
    #1;
    chk(instrWord === 14'h0000 && secondCycle === 1'b0 && cyclePhase === 2'h0,
      "mid reset");
    repeat (3) @(posedge mclk);
    #1 arst_n = 1'b1;
    issue(14'h0A00, 1'b1, 3'h0, n);
    chk(n === 4 && opCode === `IWD_OP_INC_FILE, "after reset");
    $display("reset again test done");
    print_verdict;
  end
endmodule // iwd_decoder_tb_top
